// ---- shared/fmt_consts.svh ----
// register map, field positions and timing figures of the network data formatter
`ifndef FMT_CONSTS_SVH
`define FMT_CONSTS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_INCFG 8'h04
`define ADDR_CURRENT 8'h08
`define ADDR_HOST_W0 8'h0C
`define ADDR_HOST_W1 8'h10
`define ADDR_POS_W0 8'h14
`define ADDR_POS_W1 8'h18
`define ADDR_CAPTURE 8'h1C
`define ADDR_CMD 8'h20
`define ADDR_STATUS 8'h24
`define ADDR_ENC_POS 8'h28
`define ADDR_HOST_VAL 8'h2C
`define CTRL_IN_FMT 0
`define CTRL_OUT_FMT 1
`define CTRL_BIG 2
`define CTRL_RES_LO 3
`define CTRL_RES_HI 4
`define INCFG_IN1_LO 0
`define INCFG_IN1_HI 2
`define INCFG_IN2_LO 4
`define INCFG_IN2_HI 6
`define CMD_PRESET_MOTOR 0
`define CMD_PRESET_ENC 1
`define ST_POS_RANGE 0
`define ST_HOST_ERR 1
`define ST_CAPTURED 2
`define ST_FLASH_BUSY 3
`define ST_BEACON_LOST 4
`define SPLIT_BASE 32'sh0000_03E8
`define SPLIT_MIN 32'shFE0C_0000
`define SPLIT_MAX 32'sh01F3_FFFF
`define REM_MAX 32'sh0000_03E7
`define REM_MIN 32'shFFFF_FC19
`define CURRENT_MIN 5'h01
`define CURRENT_MAX 5'h14
`define CURRENT_RST 5'h0A
`define CPR_1K 16'h0400
`define CPR_2K 16'h0800
`define CPR_4K 16'h0FE5
`define CPR_ABS 16'h0800
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_MHZ 125
`define BEACON_US 400
`endif

// ---- shared/fmt_pkg.sv ----
// types shared by the network data formatter modules
package fmt_pkg;
  typedef enum logic {FMT_SPLIT = 1'b0, FMT_S32 = 1'b1} data_fmt_t;
  typedef enum logic [1:0] {PROTO_EIP = 2'b00, PROTO_MODBUS = 2'b01, PROTO_PNET = 2'b10}
    proto_t;
  typedef enum logic [2:0] {
    FN_GP = 3'b000, FN_CW = 3'b001, FN_CCW = 3'b010, FN_HOME = 3'b011,
    FN_CAPTURE = 3'b100, FN_STOP = 3'b101, FN_START = 3'b110, FN_ESTOP = 3'b111
  } in_func_t;
  typedef enum logic {FL_IDLE = 1'b0, FL_BUSY = 1'b1} flash_state_t;
endpackage : fmt_pkg

// ---- shared/word_fmt_if.sv ----
// word-pair carrier between the formatter and its two converters
`timescale 1ns/1ps
interface word_fmt_if;
  import fmt_pkg::*;
  data_fmt_t fmt;
  logic big_endian;
  logic [31:0] value;
  logic [15:0] word0;
  logic [15:0] word1;
  logic range_err;
  modport encode (input fmt, input big_endian, input value,
    output word0, output word1, output range_err);
  modport decode (input fmt, input big_endian, input word0, input word1,
    output value, output range_err);
endinterface : word_fmt_if

// ---- logic/word_encoder.sv ----
// 32-bit value to lower/upper word pair, split or signed form
`timescale 1ns/1ps
`include "fmt_consts.svh"
module word_encoder (
  word_fmt_if.encode port
);
  import fmt_pkg::*;
  logic signed [31:0] sval;
  logic signed [31:0] quot;
  logic signed [31:0] rem;
  always_comb
  begin
    sval = $signed(port.value);
    // sv division truncates toward zero, remainder keeps the sign
    quot = sval / `SPLIT_BASE;
    rem = sval % `SPLIT_BASE;
    port.range_err = (port.fmt == FMT_SPLIT) && ((sval < `SPLIT_MIN) || (sval > `SPLIT_MAX));
    if (port.fmt == FMT_SPLIT)
    begin
      // out of range words are truncated and meaningless
      port.word0 = quot[15:0];
      port.word1 = rem[15:0];
    end
    else if (port.big_endian)
    begin
      port.word0 = port.value[31:16];
      port.word1 = port.value[15:0];
    end
    else
    begin
      port.word0 = port.value[15:0];
      port.word1 = port.value[31:16];
    end
  end
endmodule : word_encoder

// ---- logic/word_decoder.sv ----
// lower/upper word pair to 32-bit value, split or signed form
`timescale 1ns/1ps
`include "fmt_consts.svh"
module word_decoder (
  word_fmt_if.decode port
);
  import fmt_pkg::*;
  logic signed [31:0] hi;
  logic signed [31:0] lo;
  always_comb
  begin
    hi = {{16{port.word0[15]}}, port.word0};
    lo = {{16{port.word1[15]}}, port.word1};
    if (port.fmt == FMT_SPLIT)
    begin
      port.value = hi * `SPLIT_BASE + lo;
      port.range_err = (lo > `REM_MAX) || (lo < `REM_MIN);
    end
    else
    begin
      port.value = port.big_endian ? {port.word0, port.word1} : {port.word1, port.word0};
      port.range_err = 1'b0;
    end
  end
endmodule : word_decoder

// ---- logic/net_formatter.sv ----
// network data formatter: axi4-lite registers, word formats, inputs, encoder, beacon
`timescale 1ns/1ps
`include "fmt_consts.svh"
module net_formatter #(
  parameter int BEACON_CYC = `BEACON_US * `CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] din,
  input wire fmt_pkg::proto_t proto_sel,
  input wire logic enc_present,
  input wire logic enc_abs,
  input wire logic [31:0] enc_pos,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic [31:0] flash_saved,
  input wire logic flash_ack,
  input wire logic beacon_frame,
  output logic [7:0] func_active,
  output logic [4:0] motor_current,
  output logic [15:0] enc_cpr,
  output logic [31:0] motor_pos,
  output logic [31:0] host_value,
  output logic flash_req,
  output logic [31:0] flash_data,
  output logic beacon_lost
);
  import fmt_pkg::*;

  function automatic logic [7:0] decode_func(input in_func_t f, input logic lvl);
    decode_func = 8'h00;
    decode_func[f] = lvl;
  endfunction : decode_func

  word_fmt_if enc_port ();
  word_fmt_if dec_port ();
  word_encoder u_enc (.port(enc_port));
  word_decoder u_dec (.port(dec_port));

  data_fmt_t in_fmt;
  data_fmt_t out_fmt;
  logic big_endian;
  logic strap_loaded;
  logic [1:0] res_sel;
  in_func_t func1;
  in_func_t func2;
  logic [15:0] host_w0;
  logic [15:0] host_w1;
  logic [15:0] pos_w0;
  logic [15:0] pos_w1;
  logic [31:0] capture_pos;
  logic [31:0] enc_offset;
  logic [31:0] enc_report;
  logic [4:0] status_sticky;
  flash_state_t flash_state;
  logic [31:0] beacon_cnt;
  logic [1:0] din_s1;
  logic [1:0] din_s2;
  logic [1:0] din_s3;
  logic [1:0] din_f;
  logic capture_prev;
  logic capture_now;
  logic capture_edge;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_en;
  logic wr_lo;
  logic [31:0] ctrl_rd;
  logic [31:0] next_rdata;
  logic next_rvalid_err;

  assign enc_port.fmt = out_fmt;
  assign enc_port.big_endian = big_endian;
  assign enc_port.value = motor_pos;
  assign dec_port.fmt = in_fmt;
  assign dec_port.big_endian = big_endian;
  assign dec_port.word0 = host_w0;
  assign dec_port.word1 = host_w1;

  // axi4-lite write: address and data taken in any order, one write open
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_en = aw_held && w_held && !bvalid;
  // only 16-bit words are exchanged, so the low lane pair gates every write
  assign wr_lo = wr_en && (w_strb_q[1:0] == 2'h3);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_en)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_q > `ADDR_HOST_VAL || aw_addr_q[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // configuration; word order strap caught once after reset release
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      in_fmt <= FMT_SPLIT;
      out_fmt <= FMT_SPLIT;
      big_endian <= 1'b0;
      strap_loaded <= 1'b0;
      res_sel <= 2'h0;
      func1 <= FN_GP;
      func2 <= FN_GP;
      motor_current <= `CURRENT_RST;
    end
    else
    begin
      if (!strap_loaded)
      begin
        strap_loaded <= 1'b1;
        big_endian <= (proto_sel == PROTO_MODBUS) || (proto_sel == PROTO_PNET);
      end
      else if (wr_lo && aw_addr_q == `ADDR_CTRL)
      begin
        in_fmt <= data_fmt_t'(w_data_q[`CTRL_IN_FMT]);
        out_fmt <= data_fmt_t'(w_data_q[`CTRL_OUT_FMT]);
        big_endian <= w_data_q[`CTRL_BIG];
        res_sel <= w_data_q[`CTRL_RES_HI:`CTRL_RES_LO];
      end
      if (wr_lo && aw_addr_q == `ADDR_INCFG)
      begin
        func1 <= in_func_t'(w_data_q[`INCFG_IN1_HI:`INCFG_IN1_LO]);
        func2 <= in_func_t'(w_data_q[`INCFG_IN2_HI:`INCFG_IN2_LO]);
      end
      if (wr_lo && aw_addr_q == `ADDR_CURRENT)
      begin
        if (w_data_q[15:0] < 16'(`CURRENT_MIN))
          motor_current <= `CURRENT_MIN;
        else if (w_data_q[15:0] > 16'(`CURRENT_MAX))
          motor_current <= `CURRENT_MAX;
        else
          motor_current <= w_data_q[4:0];
      end
    end
  end

  // host-to-device words and their decoded value
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      host_w0 <= 16'h0000;
      host_w1 <= 16'h0000;
      host_value <= 32'h0000_0000;
    end
    else
    begin
      if (wr_lo && aw_addr_q == `ADDR_HOST_W0)
        host_w0 <= w_data_q[15:0];
      if (wr_lo && aw_addr_q == `ADDR_HOST_W1)
        host_w1 <= w_data_q[15:0];
      host_value <= dec_port.value;
    end
  end

  // device-to-host words, in the host's own format and order
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pos_w0 <= 16'h0000;
      pos_w1 <= 16'h0000;
    end
    else
    begin
      pos_w0 <= enc_port.word0;
      pos_w1 <= enc_port.word1;
    end
  end

  // three-flop input filter: a change counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      din_s1 <= 2'h0;
      din_s2 <= 2'h0;
      din_s3 <= 2'h0;
      din_f <= 2'h0;
    end
    else
    begin
      din_s1 <= din;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      for (int i = 0; i < 2; i++)
        if (din_s2[i] == din_s3[i])
          din_f[i] <= din_s3[i];
    end
  end

  assign func_active = decode_func(func1, din_f[0]) | decode_func(func2, din_f[1]);
  assign capture_now = func_active[FN_CAPTURE];
  assign capture_edge = capture_now && !capture_prev && enc_present;

  // absolute units report raw position plus the stored preset offset
  assign enc_report = enc_abs ? enc_pos + enc_offset : enc_pos;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      capture_prev <= 1'b0;
      capture_pos <= 32'h0000_0000;
    end
    else
    begin
      capture_prev <= capture_now;
      if (capture_edge)
        capture_pos <= enc_report;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      enc_cpr <= `CPR_1K;
    else if (enc_abs)
      enc_cpr <= `CPR_ABS;
    else
      case (res_sel)
        2'h0: enc_cpr <= `CPR_1K;
        2'h1: enc_cpr <= `CPR_2K;
        default: enc_cpr <= `CPR_4K;
      endcase
  end

  // motor step counter; a preset command overrides a coincident step
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      motor_pos <= 32'h0000_0000;
    else if (wr_lo && aw_addr_q == `ADDR_CMD && w_data_q[`CMD_PRESET_MOTOR])
      motor_pos <= enc_report;
    else if (step_pulse)
      motor_pos <= step_dir ? motor_pos + 32'h0000_0001 : motor_pos - 32'h0000_0001;
  end

  // encoder preset: offset restored from flash after reset, saved on every preset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      enc_offset <= 32'h0000_0000;
      flash_state <= FL_IDLE;
      flash_data <= 32'h0000_0000;
    end
    else if (!strap_loaded)
      enc_offset <= flash_saved;
    else
      case (flash_state)
        FL_IDLE:
          if (wr_lo && aw_addr_q == `ADDR_CMD && w_data_q[`CMD_PRESET_ENC] && enc_abs)
          begin
            enc_offset <= host_value - enc_pos;
            flash_data <= host_value - enc_pos;
            flash_state <= FL_BUSY;
          end
        FL_BUSY:
          if (flash_ack)
            flash_state <= FL_IDLE;
        default: flash_state <= FL_IDLE;
      endcase
  end
  assign flash_req = (flash_state == FL_BUSY);

  // beacon watchdog: each frame restarts the interval
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      beacon_cnt <= 32'h0000_0000;
      beacon_lost <= 1'b0;
    end
    else if (beacon_frame)
    begin
      beacon_cnt <= 32'h0000_0000;
      beacon_lost <= 1'b0;
    end
    else if (beacon_cnt >= 32'(BEACON_CYC))
      beacon_lost <= 1'b1;
    else
      beacon_cnt <= beacon_cnt + 32'h0000_0001;
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      status_sticky <= 5'h00;
    else
    begin
      if (wr_lo && aw_addr_q == `ADDR_STATUS)
        status_sticky <= status_sticky & ~w_data_q[4:0];
      if (enc_port.range_err)
        status_sticky[`ST_POS_RANGE] <= 1'b1;
      if (dec_port.range_err)
        status_sticky[`ST_HOST_ERR] <= 1'b1;
      if (capture_edge)
        status_sticky[`ST_CAPTURED] <= 1'b1;
    end
  end

  always_comb
  begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`CTRL_IN_FMT] = in_fmt;
    ctrl_rd[`CTRL_OUT_FMT] = out_fmt;
    ctrl_rd[`CTRL_BIG] = big_endian;
    ctrl_rd[`CTRL_RES_HI:`CTRL_RES_LO] = res_sel;
    next_rvalid_err = 1'b0;
    case (araddr)
      `ADDR_CTRL: next_rdata = ctrl_rd;
      `ADDR_INCFG: next_rdata = {25'h0, func2, 1'b0, func1};
      `ADDR_CURRENT: next_rdata = {27'h0, motor_current};
      `ADDR_HOST_W0: next_rdata = {16'h0, host_w0};
      `ADDR_HOST_W1: next_rdata = {16'h0, host_w1};
      `ADDR_POS_W0: next_rdata = {16'h0, pos_w0};
      `ADDR_POS_W1: next_rdata = {16'h0, pos_w1};
      `ADDR_CAPTURE: next_rdata = capture_pos;
      `ADDR_CMD: next_rdata = 32'h0000_0000;
      `ADDR_STATUS: next_rdata = {27'h0, beacon_lost, flash_req, status_sticky[2:0]};
      `ADDR_ENC_POS: next_rdata = enc_report;
      `ADDR_HOST_VAL: next_rdata = host_value;
      default:
      begin
        next_rdata = 32'h0000_0000;
        next_rvalid_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rvalid_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_split_words: assert property ((out_fmt == FMT_SPLIT && !enc_port.range_err) |->
    ($signed({{16{enc_port.word0[15]}}, enc_port.word0}) * `SPLIT_BASE
     + $signed({{16{enc_port.word1[15]}}, enc_port.word1}) == $signed(enc_port.value)))
    else $error("split words do not rebuild the value");
  a_split_range: assert property ((out_fmt == FMT_SPLIT) |-> (enc_port.range_err ==
    ($signed(motor_pos) < `SPLIT_MIN || $signed(motor_pos) > `SPLIT_MAX)))
    else $error("split range flag wrong");
  a_neg_sign: assert property ((out_fmt == FMT_SPLIT && motor_pos[31] && !enc_port.range_err)
    |-> ($signed(enc_port.word0) <= 0 && $signed(enc_port.word1) <= 0))
    else $error("negative split words lost the sign");
  a_word_order: assert property ((out_fmt == FMT_S32) |=>
    (pos_w0 == ($past(big_endian) ? $past(motor_pos[31:16]) : $past(motor_pos[15:0]))))
    else $error("signed word order wrong");
  a_proto_default: assert property ($rose(strap_loaded) |->
    (big_endian == ($past(proto_sel) == PROTO_MODBUS || $past(proto_sel) == PROTO_PNET)))
    else $error("word order default wrong");
  a_current_range: assert property ((motor_current >= `CURRENT_MIN)
    && (motor_current <= `CURRENT_MAX))
    else $error("motor current out of range");
  a_capture_latch: assert property (capture_edge |=> (capture_pos == $past(enc_report)))
    else $error("capture missed encoder position");
  a_preset_motor: assert property ((wr_lo && aw_addr_q == `ADDR_CMD
    && w_data_q[`CMD_PRESET_MOTOR]) |=> (motor_pos == $past(enc_report)))
    else $error("motor preset not applied");
  a_flash_hold: assert property ((flash_req && !flash_ack) |=> flash_req ##0 $stable(flash_data))
    else $error("flash request dropped early");
  a_beacon_clear: assert property (beacon_frame |=> !beacon_lost ##1 !beacon_lost)
    else $error("beacon frame not processed");
  a_write_resp: assert property (wr_en |=> bvalid)
    else $error("write response late");
  c_split_neg: cover property (out_fmt == FMT_SPLIT && motor_pos[31] && !enc_port.range_err);
  c_big_s32: cover property (out_fmt == FMT_S32 && big_endian);
  c_capture: cover property (capture_edge);
  c_flash_done: cover property (flash_req ##1 !flash_req);
endmodule : net_formatter

// ---- tb/field_model.sv ----
// far-side model: ring beacon source and flash store
`timescale 1ns/1ps
module field_model #(
  parameter int GAP = 40,
  parameter int ACK_DLY = 6
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic beacon_en,
  input wire logic flash_req,
  output logic flash_ack,
  output logic beacon_frame
);
  int bc;
  int fc;
  // gap kept below the loss limit while enabled
  always_ff @(posedge sys_clk)
    if (sys_rst || !beacon_en || bc == GAP - 1)
      bc <= 0;
    else
      bc <= bc + 1;
  assign beacon_frame = beacon_en && bc == GAP - 1;
  // slow store: the write finishes some cycles after the request
  always_ff @(posedge sys_clk)
    if (sys_rst || !flash_req)
      fc <= 0;
    else if (fc < ACK_DLY)
      fc <= fc + 1;
  assign flash_ack = flash_req && fc == ACK_DLY;
endmodule : field_model

// ---- tb/net_formatter_bench.sv ----
// self-checking bench for the network data formatter
`timescale 1ns/1ps
`include "fmt_consts.svh"
module net_formatter_bench;
  import fmt_pkg::*;
  logic sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, enc_present, enc_abs;
  logic step_pulse, step_dir, beacon_en, flash_ack, beacon_frame, awready, wready, bvalid;
  logic arready, rvalid, flash_req, beacon_lost;
  logic [7:0] awaddr, araddr, func_active;
  logic [31:0] wdata, rdata, enc_pos, motor_pos, host_value, flash_data, flash_saved;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, din;
  logic [4:0] motor_current;
  logic [15:0] enc_cpr;
  proto_t proto_sel;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] pv [3] = '{32'h01F3_FFFF, 32'hFE0C_0000, 32'h0200_0000};
  logic [31:0] pw0 [3] = '{32'h7FFF, 32'h8000, 32'h0};
  logic [31:0] pw1 [3] = '{32'h03E7, 32'h0, 32'h0};
  logic [31:0] cpr [3] = '{32'h0400, 32'h0800, 32'h0FE5};
  logic [31:0] cv [3] = '{32'h0, 32'h1F, 32'h7};
  logic [31:0] ce [3] = '{32'h1, 32'h14, 32'h7};

  net_formatter #(.BEACON_CYC(64)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .din(din), .proto_sel(proto_sel),
    .enc_present(enc_present), .enc_abs(enc_abs), .enc_pos(enc_pos),
    .step_pulse(step_pulse), .step_dir(step_dir), .flash_saved(flash_saved),
    .flash_ack(flash_ack), .beacon_frame(beacon_frame), .func_active(func_active),
    .motor_current(motor_current), .enc_cpr(enc_cpr), .motor_pos(motor_pos),
    .host_value(host_value), .flash_req(flash_req), .flash_data(flash_data),
    .beacon_lost(beacon_lost));
  field_model partner (.sys_clk(sys_clk), .sys_rst(sys_rst), .beacon_en(beacon_en),
    .flash_req(flash_req), .flash_ack(flash_ack), .beacon_frame(beacon_frame));

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // handshakes are judged at the falling edge, where ready and valid are settled
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF,
      input logic [1:0] er = `RESP_OKAY);
    bit ta, tw, tb;
    int n;
    n = 0;
    tb = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb && n < 50)
    begin
      @(negedge sys_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb)
        chk("bresp", bresp, er);
      @(posedge sys_clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      n++;
    end
    if (!tb)
      chk("write answer", 32'h0, 32'h1);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er = `RESP_OKAY);
    bit ta, tr;
    int n;
    n = 0;
    tr = 0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr && n < 50)
    begin
      @(negedge sys_clk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr)
      begin
        chk($sformatf("reg %h", a), rdata & m, e);
        chk("rresp", rresp, er);
      end
      @(posedge sys_clk);
      if (ta)
        arvalid <= 1'b0;
      n++;
    end
    if (!tr)
      chk("read answer", 32'h0, 32'h1);
  endtask : axr

  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : pause

  task automatic hv(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] e);
    axw(`ADDR_HOST_W0, w0);
    axw(`ADDR_HOST_W1, w1);
    axr(`ADDR_HOST_VAL, 32'hFFFF_FFFF, e);
    pause(0);
    chk("host_value", host_value, e);
    @(posedge sys_clk);
  endtask : hv

  task automatic ow(input logic [31:0] c, input logic [31:0] w0, input logic [31:0] w1);
    axw(`ADDR_CTRL, c);
    axr(`ADDR_POS_W0, 32'hFFFF, w0);
    axr(`ADDR_POS_W1, 32'hFFFF, w1);
  endtask : ow

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    int n;
    sys_rst = 1'b1;
    {awvalid, wvalid, arvalid, step_pulse, enc_abs} = 5'h00;
    {bready, rready, enc_present, step_dir, beacon_en} = 5'h1F;
    {awaddr, araddr, din, wdata, enc_pos, wstrb} = 86'h0;
    flash_saved = 32'h0000_0064;
    proto_sel = PROTO_MODBUS;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pause(2);
    chk("current", motor_current, 32'h0A);
    chk("cpr", enc_cpr, 32'h0400);
    @(posedge sys_clk);
    axr(`ADDR_CTRL, 32'h1F, 32'h04);
    for (int i = 0; i < 3; i++)
    begin
      axw(`ADDR_CURRENT, cv[i]);
      axr(`ADDR_CURRENT, 32'h1F, ce[i]);
    end
    axw(`ADDR_CURRENT, 32'h3, 4'h1);
    axr(`ADDR_CURRENT, 32'h1F, 32'h7);
    for (int i = 0; i < 3; i++)
    begin
      axw(`ADDR_CTRL, (i << 3) | 4);
      pause(0);
      chk("cpr", enc_cpr, cpr[i]);
      @(posedge sys_clk);
    end
    axw(`ADDR_CTRL, 32'h0);
    hv(32'h000C, 32'h0159, 32'h0000_3039);
    hv(32'hFFFF, 32'hFE0C, 32'hFFFF_FA24);
    axw(`ADDR_CTRL, 32'h5);
    hv(32'h0001, 32'hE240, 32'h0001_E240);
    axw(`ADDR_CTRL, 32'h1);
    hv(32'h0001, 32'hE240, 32'hE240_0001);
    enc_pos <= 32'h0001_E240;
    axw(`ADDR_CMD, 32'h1);
    pause(0);
    chk("motor_pos", motor_pos, 32'h0001_E240);
    @(posedge sys_clk);
    ow(32'h6, 32'h0001, 32'hE240);
    ow(32'h2, 32'hE240, 32'h0001);
    ow(32'h1, 32'h007B, 32'h01C8);
    step_dir <= 1'b0;
    step_pulse <= 1'b1;
    @(posedge sys_clk);
    step_pulse <= 1'b0;
    pause(2);
    chk("motor_pos", motor_pos, 32'h0001_E23F);
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
    begin
      enc_pos <= pv[i];
      axw(`ADDR_CMD, 32'h1);
      if (i < 2)
      begin
        axr(`ADDR_POS_W0, 32'hFFFF, pw0[i]);
        axr(`ADDR_POS_W1, 32'hFFFF, pw1[i]);
      end
      axr(`ADDR_STATUS, 32'h1, i == 2);
    end
    for (int k = 0; k < 8; k++)
    begin
      axw(`ADDR_INCFG, k | ((7 - k) << 4));
      din <= 2'b11;
      pause(6);
      chk("func_active", func_active, (1 << k) | (1 << (7 - k)));
      @(posedge sys_clk);
      din <= 2'b00;
      pause(6);
      chk("func idle", func_active, 32'h0);
      @(posedge sys_clk);
    end
    axw(`ADDR_INCFG, 32'h4);
    // clear the flag left by the input sweep so the capture below must set it again
    axw(`ADDR_STATUS, 32'h4);
    enc_pos <= 32'h0000_0ABC;
    din <= 2'b01;
    repeat (6) @(posedge sys_clk);
    enc_pos <= 32'h0000_0DEF;
    axr(`ADDR_CAPTURE, 32'hFFFF_FFFF, 32'h0000_0ABC);
    axr(`ADDR_STATUS, 32'h4, 32'h4);
    axw(`ADDR_STATUS, 32'h4);
    axr(`ADDR_STATUS, 32'h4, 32'h0);
    din <= 2'b00;
    pause(0);
    chk("beacon ok", beacon_lost, 32'h0);
    @(posedge sys_clk);
    beacon_en <= 1'b0;
    pause(100);
    chk("beacon lost", beacon_lost, 32'h1);
    @(posedge sys_clk);
    axr(`ADDR_STATUS, 32'h10, 32'h10);
    beacon_en <= 1'b1;
    pause(60);
    chk("beacon back", beacon_lost, 32'h0);
    @(posedge sys_clk);
    // no encoder fitted: a capture edge must leave the latched value alone
    enc_present <= 1'b0;
    din <= 2'b01;
    repeat (6) @(posedge sys_clk);
    axr(`ADDR_CAPTURE, 32'hFFFF_FFFF, 32'h0000_0ABC);
    enc_abs <= 1'b1;
    enc_pos <= 32'h0000_03E8;
    pause(2);
    chk("abs cpr", enc_cpr, 32'h0800);
    @(posedge sys_clk);
    axr(`ADDR_ENC_POS, 32'hFFFF_FFFF, 32'h0000_044C);
    axw(`ADDR_CTRL, 32'h0);
    hv(32'h0005, 32'h0000, 32'h0000_1388);
    axw(`ADDR_CMD, 32'h2);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (flash_req !== 1'b1 && n < 20);
    chk("flash_data", flash_data, 32'h0000_0FA0);
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (flash_req !== 1'b0 && n < 60);
    chk("flash done", flash_req, 32'h0);
    @(posedge sys_clk);
    axr(`ADDR_ENC_POS, 32'hFFFF_FFFF, 32'h0000_1388);
    axw(8'h30, 32'h1, 4'hF, `RESP_SLVERR);
    axr(8'h30, 32'hFFFF_FFFF, 32'h0, `RESP_SLVERR);
    // mid-run reset with the other protocol strap: little-endian default expected
    sys_rst <= 1'b1;
    proto_sel <= PROTO_EIP;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    axr(`ADDR_CTRL, 32'h1F, 32'h00);
    pause(0);
    chk("current", motor_current, 32'h0A);
    tally_and_finish();
  end
endmodule : net_formatter_bench
